// ===== verilog/adsc_control.sv
`timescale 1ns/1ps
`default_nettype none
module adsc_control import adsc_pkg::*; (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // CPU register port
  input wire adsc_bus_t i_bus,
  output logic [7:0] o_rdata,
  // Comparator from analog core
  input wire logic i_cmp_hi,
  // External interrupt 1 source
  input wire logic i_ext_irq1,
  // Analog side
  output logic [7:0] o_ch_connect,
  output logic [2:0] o_mux_sel,
  output logic [7:0] o_dac_code,
  // Interrupt line 1
  output logic o_irq1
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [7:0] ctrl_r, ctrl_nxt;
  logic [7:0] presc_r, presc_nxt;
  logic [7:0] chen_r, chen_nxt;
  logic [7:0] result_r, result_nxt;
  logic [7:0] sar_r, sar_nxt;
  logic [7:0] bit_r, bit_nxt;
  logic [6:0] div_r, div_nxt;
  logic [1:0] base_r, base_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [7:0] conn_r, conn_nxt;
  logic irq_r, irq_nxt;
  logic cmp_m_r, cmp_r, ext_m_r, ext_r;
  adsc_state_t st_r, st_nxt;
  logic tick, ch_ok, go;
  logic [6:0] div_lim;

  always_comb begin
    div_lim = 7'((8'h01 << presc_r[ADSC_B_DIV_LO +: 3]) - 8'h01);
    tick = (base_r == ADSC_BASE_DIV) && (div_r == div_lim);
    ch_ok = ctrl_r[ADSC_B_GEN] && chen_r[ctrl_r[2:0]];
    go = i_bus.wr && (i_bus.addr == ADSC_OFF_CTRL) && i_bus.wdata[ADSC_B_START];
  end

  // ----------------------------------------
  // Registers, sequencer and read mux
  // ----------------------------------------
  always_comb begin
    ctrl_nxt = ctrl_r;
    presc_nxt = presc_r;
    chen_nxt = chen_r;
    result_nxt = result_r;
    sar_nxt = sar_r;
    bit_nxt = bit_r;
    st_nxt = st_r;
    // Converter pulse owns line 1 while selected
    irq_nxt = ctrl_r[ADSC_B_IRQS] ? 1'b0 : ext_r;
    base_nxt = (base_r == ADSC_BASE_DIV) ? 2'h0 : 2'(base_r + 2'h1);
    div_nxt = div_r;
    if (base_r == ADSC_BASE_DIV) begin
      div_nxt = tick ? 7'h00 : 7'(div_r + 7'h01);
    end
    if (i_bus.wr) begin
      case (i_bus.addr)
        ADSC_OFF_CTRL: begin
          // Done is read only; start belongs to the sequencer, so a
          // repeated start while busy cannot drop the busy flag
          ctrl_nxt = (i_bus.wdata & ADSC_CTRL_WMASK & ~(8'h01 << ADSC_B_START))
                   | (ctrl_r & ~(ADSC_CTRL_WMASK & ~(8'h01 << ADSC_B_START)));
        end
        ADSC_OFF_PRESC: presc_nxt = i_bus.wdata & ADSC_PRESC_MASK;
        ADSC_OFF_CHEN: chen_nxt = i_bus.wdata;
        default: begin
        end
      endcase
    end
    case (st_r)
      ADSC_IDLE: begin
        if (go && i_bus.wdata[ADSC_B_GEN] && chen_r[i_bus.wdata[2:0]]) begin
          ctrl_nxt[ADSC_B_START] = 1'b1;
          ctrl_nxt[ADSC_B_DONE] = 1'b0;
          sar_nxt = 8'h80;
          bit_nxt = 8'h80;
          div_nxt = 7'h00;
          // Restart base divider so the first decision sees a settled comparator
          base_nxt = 2'h0;
          st_nxt = ADSC_STEP;
        end
      end
      ADSC_STEP: begin
        // Writing zero to start aborts; result keeps its old value
        if ((i_bus.wr && i_bus.addr == ADSC_OFF_CTRL && !i_bus.wdata[ADSC_B_START])
            || !ch_ok) begin
          ctrl_nxt[ADSC_B_START] = 1'b0;
          ctrl_nxt[ADSC_B_DONE] = 1'b1;
          st_nxt = ADSC_IDLE;
        end else if (tick) begin
          // One decision per divided clock, MSB first
          sar_nxt = cmp_r ? sar_r : (sar_r & ~bit_r);
          sar_nxt = sar_nxt | (bit_r >> 1);
          bit_nxt = bit_r >> 1;
          if (bit_r == 8'h01) begin
            st_nxt = ADSC_DONE;
          end
        end
      end
      ADSC_DONE: begin
        result_nxt = sar_r;
        ctrl_nxt[ADSC_B_DONE] = 1'b1;
        ctrl_nxt[ADSC_B_START] = 1'b0;
        if (ctrl_r[ADSC_B_IRQS]) begin
          irq_nxt = 1'b1;
        end
        st_nxt = ADSC_IDLE;
      end
      default: st_nxt = ADSC_IDLE;
    endcase
    case (i_bus.addr)
      ADSC_OFF_CTRL: rdata_nxt = ctrl_r & ~8'h08;
      ADSC_OFF_PRESC: rdata_nxt = presc_r;
      ADSC_OFF_RESULT: rdata_nxt = result_r;
      ADSC_OFF_CHEN: rdata_nxt = chen_r;
      default: rdata_nxt = 8'h00;
    endcase
    if (!i_bus.rd) begin
      rdata_nxt = rdata_r;
    end
    conn_nxt = ctrl_nxt[ADSC_B_GEN] ? chen_nxt : 8'h00;
  end

  always_ff @(posedge i_clk_sys) begin
    cmp_m_r <= i_cmp_hi;
    cmp_r <= cmp_m_r;
    ext_m_r <= i_ext_irq1;
    ext_r <= ext_m_r;
    if (!i_rst_n) begin
      ctrl_r <= ADSC_CTRL_RST;
      presc_r <= ADSC_PRESC_RST;
      chen_r <= ADSC_CHEN_RST;
      result_r <= 8'h00;
      sar_r <= 8'h00;
      bit_r <= 8'h00;
      div_r <= 7'h00;
      base_r <= 2'h0;
      rdata_r <= 8'h00;
      conn_r <= 8'h00;
      irq_r <= 1'b0;
      st_r <= ADSC_IDLE;
    end else begin
      ctrl_r <= ctrl_nxt;
      presc_r <= presc_nxt;
      chen_r <= chen_nxt;
      result_r <= result_nxt;
      sar_r <= sar_nxt;
      bit_r <= bit_nxt;
      div_r <= div_nxt;
      base_r <= base_nxt;
      rdata_r <= rdata_nxt;
      conn_r <= conn_nxt;
      irq_r <= irq_nxt;
      st_r <= st_nxt;
    end
  end

  assign o_rdata = rdata_r;
  assign o_ch_connect = conn_r;
  assign o_mux_sel = ctrl_r[2:0];
  assign o_dac_code = sar_r;
  assign o_irq1 = irq_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  global_off_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !ctrl_r[ADSC_B_GEN] |-> o_ch_connect == 8'h00) else $error("inputs connected");
  per_chan_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    ctrl_r[ADSC_B_GEN] |-> o_ch_connect == chen_r) else $error("chan map");
  busy_flag_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    st_r == ADSC_STEP |-> !ctrl_r[ADSC_B_DONE] && ctrl_r[ADSC_B_START])
    else $error("busy flags");
  done_clear_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    st_r == ADSC_DONE |=> ctrl_r[ADSC_B_DONE] && !ctrl_r[ADSC_B_START]
    && result_r == $past(sar_r)) else $error("completion");
  start_go_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    st_r == ADSC_IDLE && go && i_bus.wdata[ADSC_B_GEN] && chen_r[i_bus.wdata[2:0]]
    |=> st_r == ADSC_STEP && sar_r == 8'h80) else $error("no start");
  start_ign_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    st_r == ADSC_IDLE && go && !(i_bus.wdata[ADSC_B_GEN] && chen_r[i_bus.wdata[2:0]])
    |=> st_r == ADSC_IDLE && $stable(result_r) && ctrl_r[ADSC_B_DONE])
    else $error("bad start taken");
  abort_wr_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    st_r == ADSC_STEP && i_bus.wr && i_bus.addr == ADSC_OFF_CTRL
    && !i_bus.wdata[ADSC_B_START] |=> st_r == ADSC_IDLE && ctrl_r[ADSC_B_DONE]
    && $stable(result_r)) else $error("stop ignored");
  abort_chan_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    st_r == ADSC_STEP && !ch_ok |=> st_r == ADSC_IDLE && ctrl_r[ADSC_B_DONE]
    && !ctrl_r[ADSC_B_START]) else $error("disabled channel kept");
  irq_route_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    ctrl_r[ADSC_B_IRQS] && st_r != ADSC_DONE |=> !o_irq1) else $error("ext leak");
  irq_raise_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    ctrl_r[ADSC_B_IRQS] && st_r == ADSC_DONE |=> o_irq1) else $error("no irq");
  irq_pass_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !ctrl_r[ADSC_B_IRQS] |=> o_irq1 == $past(ext_r)) else $error("ext lost");
  mux_sel_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_bus.wr && i_bus.addr == ADSC_OFF_CTRL
    |=> o_mux_sel == $past(i_bus.wdata[2:0])) else $error("mux");
  step_tick_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    st_r == ADSC_STEP && !tick && ch_ok && !(i_bus.wr && i_bus.addr == ADSC_OFF_CTRL)
    |=> $stable(bit_r)) else $error("step off tick");
  cmp_settle_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    $rose(st_r == ADSC_STEP) |-> !tick ##1 !tick) else $error("early decision");
  result_hold_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    st_r != ADSC_DONE |=> $stable(result_r)) else $error("result moved");
  reset_val_a: assert property (@(posedge i_clk_sys)
    !i_rst_n |=> ctrl_r == 8'h20 && chen_r == 8'h00) else $error("reset");
  conv_c: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n) st_r == ADSC_DONE);
  abort_c: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    st_r == ADSC_STEP ##1 st_r == ADSC_IDLE);
  irq_c: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    ctrl_r[ADSC_B_IRQS] && o_irq1);
  ign_c: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    st_r == ADSC_IDLE && go && !(i_bus.wdata[ADSC_B_GEN] && chen_r[i_bus.wdata[2:0]]));
endmodule
`default_nettype wire

// ===== verilog/adsc_pkg.sv
// Overview of operation
// - Global enable off disconnects every input
// - Global enable on uses per-channel bits
// - Eight channel enable bits, one enables
// - Writing start bit begins conversion
// - Done low while busy, clears start
// - Irq select replaces external interrupt one
// - Three-bit select picks one of eight
// - Divider scales converter clock by powers two
// - Result register, bit seven most significant
// - Successive approximation, one bit per step
// - Reset: control reads done only, enables zero
package adsc_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [15:0] ADSC_OFF_CTRL = 16'h8020;
  localparam logic [15:0] ADSC_OFF_PRESC = 16'h8021;
  localparam logic [15:0] ADSC_OFF_RESULT = 16'h8022;
  localparam logic [15:0] ADSC_OFF_CHEN = 16'h802a;
  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int ADSC_B_GEN = 7;
  localparam int ADSC_B_START = 6;
  localparam int ADSC_B_DONE = 5;
  localparam int ADSC_B_IRQS = 4;
  localparam int ADSC_B_DIV_LO = 4;
  localparam logic [7:0] ADSC_CTRL_RST = 8'h20;
  localparam logic [7:0] ADSC_CTRL_WMASK = 8'hd7;
  localparam logic [7:0] ADSC_PRESC_RST = 8'h20;
  localparam logic [7:0] ADSC_PRESC_MASK = 8'h70;
  localparam logic [7:0] ADSC_CHEN_RST = 8'h00;
  // Base tick: converter input clock is the oscillator over three
  localparam logic [1:0] ADSC_BASE_DIV = 2'h2;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } adsc_bus_t;
  typedef enum logic [2:0] {
    ADSC_IDLE = 3'h1,
    ADSC_STEP = 3'h2,
    ADSC_DONE = 3'h4
  } adsc_state_t;
endpackage

// ===== bench/adsc_analog_model.sv
`timescale 1ns/1ps
`default_nettype none
module adsc_analog_model (
  // Clock
  input wire logic i_clk_sys,
  // Converter side
  input wire logic [7:0] i_ch_connect,
  input wire logic [2:0] i_mux_sel,
  input wire logic [7:0] i_dac_code,
  input wire logic [63:0] i_levels,
  // Comparator
  output logic o_cmp_hi
);
  logic fl_r = 1'b0;
  // Open switch floats, so the comparator wanders
  always_ff @(posedge i_clk_sys) fl_r <= ~fl_r;
  assign o_cmp_hi = i_ch_connect[i_mux_sel] ?
    (i_levels[i_mux_sel*8 +: 8] >= i_dac_code) : fl_r;
endmodule
`default_nettype wire

// ===== bench/adsc_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
  $display("Error t=%0t got=%h exp=%h", $time, g, e); end end
module adsc_control_tb;
  import adsc_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ext_irq = 1'b0;
  logic rd_d = 1'b0;
  adsc_bus_t bus = '0;
  logic [63:0] levels = '0;
  logic cmp_hi, irq;
  logic [7:0] rdata, connect, dac, lv, ch;
  logic [2:0] mux;
  logic [15:0] exp_q[$];
  logic [15:0] e;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  int irq_cnt = 0;
  int g, s, a;
  always #10 clk = ~clk;
  adsc_control dut_u (.i_clk_sys(clk), .i_rst_n(rst_n), .i_bus(bus), .o_rdata(rdata),
    .i_cmp_hi(cmp_hi), .i_ext_irq1(ext_irq), .o_ch_connect(connect), .o_mux_sel(mux),
    .o_dac_code(dac), .o_irq1(irq));
  adsc_analog_model ana_u (.i_clk_sys(clk), .i_ch_connect(connect), .i_mux_sel(mux),
    .i_dac_code(dac), .i_levels(levels), .o_cmp_hi(cmp_hi));
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    bus.wr = 1'b1;
    bus.addr = a;
    bus.wdata = d;
    @(negedge clk);
    bus.wr = 1'b0;
  endtask
  // Note the expectation, then issue the read
  task automatic rd(input logic [15:0] a, input logic [7:0] m, input logic [7:0] x);
    exp_q.push_back({m, x & m});
    @(negedge clk);
    bus.rd = 1'b1;
    bus.addr = a;
    @(negedge clk);
    bus.rd = 1'b0;
  endtask
  task automatic wait_done;
    int n;
    n = 0;
    do begin
      rd(ADSC_OFF_CTRL, 8'h00, 8'h00);
      n++;
    end while (rdata[ADSC_B_DONE] !== 1'b1 && n < 2000);
    `CHK(rdata[ADSC_B_DONE], 1'b1)
  endtask
  // Cycles between the second and third trial code changes
  task automatic gap(output int n);
    int k;
    logic [7:0] p;
    k = 0;
    n = 0;
    p = dac;
    while (k < 3 && n < 4000) begin
      @(negedge clk);
      n++;
      if (dac !== p) begin
        k++;
        p = dac;
        if (k == 2) n = 0;
      end
    end
  endtask
  always @(posedge clk) begin
    rd_d <= bus.rd;
    cycles <= cycles + 1;
    irq_cnt <= irq_cnt + int'(irq);
    if (cycles == 30000) begin
      miscompares++;
      close_out();
    end
  end
  always @(negedge clk) if (rd_d === 1'b1) begin
    e = exp_q.pop_front();
    if (e[15:8] != 8'h00) `CHK(rdata & e[15:8], e[7:0])
  end
  initial begin
    void'($urandom(32'hf819a320));
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    `CHK(connect, 8'h00)
    rd(ADSC_OFF_CTRL, 8'hff, ADSC_CTRL_RST);
    rd(ADSC_OFF_CHEN, 8'hff, ADSC_CHEN_RST);
    rd(ADSC_OFF_PRESC, ADSC_PRESC_MASK, ADSC_PRESC_RST);
    s = $urandom_range(7);
    ch = ~(8'h01 << s);
    wr(ADSC_OFF_CHEN, ch);
    rd(ADSC_OFF_CHEN, 8'hff, ch);
    @(negedge clk);
    `CHK(connect, 8'h00)
    wr(ADSC_OFF_CTRL, 8'h80);
    @(negedge clk);
    `CHK(connect, ch)
    wr(ADSC_OFF_CTRL, 8'hc0 | 8'(s));
    rd(ADSC_OFF_CTRL, 8'hff, 8'ha0 | 8'(s));
    rd(ADSC_OFF_RESULT, 8'hff, 8'h00);
    for (int c = 0; c < 8; c++) if (c != s) begin
      lv = 8'($urandom);
      levels[c*8 +: 8] = lv;
      wr(ADSC_OFF_PRESC, {1'b0, 3'(c), 4'h0});
      irq_cnt = 0;
      ext_irq = 1'b1;
      wr(ADSC_OFF_CTRL, 8'hd0 | 8'(c));
      rd(ADSC_OFF_CTRL, 8'h20, 8'h00);
      `CHK(mux, 3'(c))
      gap(g);
      `CHK(g, 3 << c)
      wait_done;
      rd(ADSC_OFF_CTRL, 8'hff, 8'hb0 | 8'(c));
      rd(ADSC_OFF_RESULT, 8'hff, lv);
      `CHK(irq_cnt, 1)
    end
    // Abort by stop write, then by channel disable; result holds
    a = (s + 1) % 8;
    for (int k = 0; k < 2; k++) begin
      irq_cnt = 0;
      wr(ADSC_OFF_CTRL, 8'hd0 | 8'(a));
      rd(ADSC_OFF_CTRL, 8'h60, 8'h40);
      if (k == 0) wr(ADSC_OFF_CTRL, 8'h90 | 8'(a));
      else wr(ADSC_OFF_CHEN, 8'h00);
      rd(ADSC_OFF_CTRL, 8'hff, 8'hb0 | 8'(a));
      rd(ADSC_OFF_RESULT, 8'hff, lv);
      `CHK(irq_cnt, 0)
    end
    // Select off hands the line back to the pin
    wr(ADSC_OFF_CTRL, 8'h80);
    repeat (5) @(negedge clk);
    `CHK(irq, 1'b1)
    close_out();
  end
endmodule
`default_nettype wire
